// File: core/dvs_dac_volume.sv
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
module dvs_dac_volume
  import dvs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dvs_sample_type in_sample,
  input wire logic in_valid,
  output logic in_ready,
  output dvs_sample_type dac_data,
  output logic dac_valid,
  output logic dac_power,
  output logic ana_l_power,
  output logic ana_r_power,
  output logic fx_active,
  output logic deemph_active,
  output logic [1:0] cm_select,
  output logic [1:0] bias_current,
  output logic [4*NUM_INPUTS-1:0] input_level,
  output logic [2*NUM_INPUTS-1:0] input_route
);
  // ---------------------------------------------------------------
  // Register file and AXI4-Lite slave
  // ---------------------------------------------------------------
  logic [31:0] ctrl, vol_l, vol_r, rate, in_level_req, in_route, pga_ss, drange;
  logic [31:0] aw_addr, w_data, status;
  logic [3:0] w_strb;
  logic aw_held, w_held, vol_reached, pd_done;
  logic [7:0] applied [2];
  logic [7:0] target [2];
  dvs_state_type state;
  logic [6:0] widx, ridx;
  logic [31:0] wmask;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign widx = aw_addr[8:2];
  assign ridx = s_axi_araddr[8:2];
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nv & m);
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:9] == 23'h0) && (a[1:0] == 2'h0) &&
             ((a[8:2] <= IDX_PGA_SS) || (a[8:2] == IDX_DRANGE));
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      vol_l <= VOL_RESET;
      vol_r <= VOL_RESET;
      rate <= RATE_RESET;
      in_level_req <= 32'h0000_0000;
      in_route <= 32'h0000_0000;
      pga_ss <= 32'h0000_0000;
      drange <= DRANGE_RESET;
    end else if (aw_held && w_held && mapped(aw_addr)) begin
      case (widx)
        IDX_CTRL: ctrl <= merge(ctrl, w_data, wmask) & 32'h0000_037F;
        IDX_VOL_L: vol_l <= merge(vol_l, w_data, wmask) & 32'h0000_00FF;
        IDX_VOL_R: vol_r <= merge(vol_r, w_data, wmask) & 32'h0000_00FF;
        IDX_MASTER: begin
          vol_l <= merge(vol_l, w_data, wmask) & 32'h0000_00FF;
          vol_r <= merge(vol_r, w_data, wmask) & 32'h0000_00FF;
        end
        IDX_RATE: rate <= merge(rate, w_data, wmask) & 32'h0000_0007;
        IDX_IN_LEVEL: in_level_req <= merge(in_level_req, w_data, wmask) & 32'h00FF_FFFF;
        IDX_IN_ROUTE: in_route <= merge(in_route, w_data, wmask) & 32'h0000_3F3F;
        IDX_PGA_SS: pga_ss <= merge(pga_ss, w_data, wmask) & 32'h0000_0003;
        IDX_DRANGE: drange <= merge(drange, w_data, wmask) & 32'h0000_00C0;
        default: ctrl <= ctrl;
      endcase
    end
  end

  assign status = {8'h00, applied[1], applied[0], 3'h0, fx_active, state[1:0],
                   pd_done, vol_reached};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (ridx)
        IDX_CTRL: s_axi_rdata <= ctrl;
        IDX_VOL_L: s_axi_rdata <= vol_l;
        IDX_VOL_R: s_axi_rdata <= vol_r;
        IDX_MASTER: s_axi_rdata <= vol_l;
        IDX_RATE: s_axi_rdata <= rate;
        IDX_STATUS: s_axi_rdata <= status;
        IDX_IN_LEVEL: s_axi_rdata <= in_level_req;
        IDX_IN_ROUTE: s_axi_rdata <= in_route;
        IDX_PGA_SS: s_axi_rdata <= pga_ss;
        IDX_DRANGE: s_axi_rdata <= drange;
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign cm_select = ctrl[CTRL_CM_LSB+1:CTRL_CM_LSB];
  assign bias_current = drange[DRANGE_LSB+1:DRANGE_LSB];
  assign input_route = {in_route[13:8], in_route[5:0]};
  assign ana_l_power = dac_power && ctrl[CTRL_ANA_L_PWR];
  assign ana_r_power = dac_power && ctrl[CTRL_ANA_R_PWR];

  // ---------------------------------------------------------------
  // Rate generation
  // ---------------------------------------------------------------
  // A modulator tick is 128 times the reference rate; one input sample
  // is taken every 128 * divider ticks, so the output rate never moves.
  logic [4:0] tick_cnt;
  logic [9:0] osr_cnt;
  logic [2:0] div;
  logic mod_tick, sample_tick, half_q, step_now;
  assign div = (rate[2:0] == 3'h0) ? 3'h1 : rate[2:0];
  assign mod_tick = (tick_cnt == 5'(MOD_TICK_CYCLES - 1));
  assign sample_tick = mod_tick && (osr_cnt == 10'h000);
  assign in_ready = sample_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 5'h00;
    end else begin
      tick_cnt <= mod_tick ? 5'h00 : tick_cnt + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osr_cnt <= 10'h000;
    end else if (mod_tick) begin
      osr_cnt <= (osr_cnt == 10'h000) ? 10'({div, 7'h00} - 10'h001) : osr_cnt - 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q <= 1'b0;
    end else if (sample_tick) begin
      half_q <= !half_q;
    end
  end

  assign step_now = sample_tick && (!ctrl[CTRL_SS_SLOW] || half_q);

  // ---------------------------------------------------------------
  // Mute sequencer
  // ---------------------------------------------------------------
  logic all_muted, fx_req, deemph_req;
  assign all_muted = (applied[0] == MUTE_STEP) && (applied[1] == MUTE_STEP);
  assign fx_req = ctrl[CTRL_EFFECTS];
  assign deemph_req = ctrl[CTRL_DEEMPH];
  assign dac_power = (state != ST_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_OFF;
      pd_done <= 1'b1;
      fx_active <= 1'b0;
      deemph_active <= 1'b0;
    end else begin
      case (state)
        ST_OFF: begin
          if (ctrl[CTRL_DAC_PWR]) begin
            state <= ST_RUN;
            pd_done <= 1'b0;
            fx_active <= fx_req;
            deemph_active <= deemph_req;
          end
        end
        ST_RUN: begin
          if (!ctrl[CTRL_DAC_PWR]) begin
            state <= ST_PD_MUTE;
          end else if (fx_req != fx_active || deemph_req != deemph_active) begin
            state <= ST_FX_MUTE;
          end
        end
        ST_FX_MUTE: begin
          if (all_muted) begin
            fx_active <= fx_req;
            deemph_active <= deemph_req;
            state <= ST_RUN;
          end
        end
        ST_PD_MUTE: begin
          if (all_muted) begin
            state <= ST_OFF;
            pd_done <= 1'b1;
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Per-channel soft-stepped volume and interpolation
  // ---------------------------------------------------------------
  logic [15:0] line_l [GROUP_DELAY+1];
  logic [15:0] line_r [GROUP_DELAY+1];
  logic [17:0] recip;
  always_comb begin
    case (div)
      3'h1: recip = 18'h20000;
      3'h2: recip = 18'h10000;
      3'h3: recip = 18'h0AAAB;
      3'h4: recip = 18'h08000;
      3'h5: recip = 18'h06666;
      3'h6: recip = 18'h05555;
      default: recip = 18'h0492E;
    endcase
  end

  // A 21-sample delay then linear interpolation: the response is
  // symmetric, hence linear phase; deeper image rejection would need a
  // long FIR, which was traded for area here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i <= GROUP_DELAY; i++) begin
        line_l[i] <= 16'h0000;
        line_r[i] <= 16'h0000;
      end
    end else if (sample_tick) begin
      line_l[0] <= in_valid ? in_sample.left : 16'h0000;
      line_r[0] <= in_valid ? in_sample.right : 16'h0000;
      for (int i = 1; i <= GROUP_DELAY; i++) begin
        line_l[i] <= line_l[i-1];
        line_r[i] <= line_r[i-1];
      end
    end
  end

  function automatic logic [15:0] mant(input logic [3:0] k);
    case (k)
      4'h0: mant = 16'h8000;
      4'h1: mant = 16'h78D7;
      4'h2: mant = 16'h7215;
      4'h3: mant = 16'h6BB3;
      4'h4: mant = 16'h65AD;
      4'h5: mant = 16'h5FFD;
      4'h6: mant = 16'h5A9E;
      4'h7: mant = 16'h558C;
      4'h8: mant = 16'h50C3;
      4'h9: mant = 16'h4C3F;
      4'hA: mant = 16'h47FB;
      default: mant = 16'h43F4;
    endcase
  endfunction

  logic [15:0] ch_out [2];
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic [15:0] newer, older;
      logic signed [41:0] acc;
      logic signed [16:0] diff;
      logic signed [35:0] incr;
      logic signed [33:0] prod;
      logic [7:0] req;
      assign newer = (c == 0) ? line_l[GROUP_DELAY-1] : line_r[GROUP_DELAY-1];
      assign older = (c == 0) ? line_l[GROUP_DELAY] : line_r[GROUP_DELAY];
      assign req = (c == 0) ? vol_l[7:0] : vol_r[7:0];
      // Mute and the sequencer's mute states ask for full attenuation.
      assign target[c] = (req[VOL_MUTE_BIT] || state != ST_RUN) ?
                         MUTE_STEP : {1'b0, req[6:0]};
      assign diff = $signed({newer[15], newer}) - $signed({older[15], older});
      assign incr = diff * $signed({1'b0, recip});

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          acc <= 42'sh0;
        end else if (sample_tick) begin
          acc <= {{2{older[15]}}, older, 24'h000000};
        end else if (mod_tick) begin
          acc <= acc + 42'(incr);
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          applied[c] <= MUTE_STEP;
        end else if (state == ST_OFF) begin
          applied[c] <= MUTE_STEP;
        end else if (ctrl[CTRL_SS_DIS]) begin
          applied[c] <= target[c];
        end else if (step_now && applied[c] < target[c]) begin
          applied[c] <= applied[c] + 8'h01;
        end else if (step_now && applied[c] > target[c]) begin
          applied[c] <= applied[c] - 8'h01;
        end
      end

      assign prod = $signed(acc[39:24]) * $signed({1'b0, mant(4'(applied[c][6:0] % 7'd12))});
      assign ch_out[c] = (applied[c] == MUTE_STEP) ? 16'h0000 :
                         16'(prod >>> (15 + applied[c][6:0] / 7'd12));
    end
  endgenerate

  assign vol_reached = (applied[0] == target[0]) && (applied[1] == target[1]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_data <= '0;
      dac_valid <= 1'b0;
    end else begin
      dac_valid <= mod_tick;
      if (mod_tick) begin
        dac_data.left <= ana_l_power ? ch_out[0] : 16'h0000;
        dac_data.right <= ana_r_power ? ch_out[1] : 16'h0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Input level controls
  // ---------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < NUM_INPUTS; n++) begin : g_in
      logic [3:0] lvl, req;
      assign req = (in_level_req[4*n+3:4*n] > IN_MUTE_LEVEL) ? IN_MUTE_LEVEL :
                   in_level_req[4*n+3:4*n];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          lvl <= 4'h0;
        end else if (pga_ss[0]) begin
          lvl <= req;
        end else if (sample_tick && (!pga_ss[1] || half_q) && lvl != req) begin
          lvl <= (lvl < req) ? lvl + 4'h1 : lvl - 4'h1;
        end
      end
      assign input_level[4*n+3:4*n] = lvl;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_step_one;
    @(posedge aclk) disable iff (!aresetn)
      ($changed(applied[0]) && !$past(ctrl[CTRL_SS_DIS]) && $past(state) != ST_OFF) |->
        ($past(step_now) && (applied[0] - $past(applied[0]) == 8'h01 ||
                            $past(applied[0]) - applied[0] == 8'h01));
  endproperty
  a_step_one: assert property (p_step_one) else $error("gain moved off a sample step");

  property p_slow;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl[CTRL_SS_SLOW] && !ctrl[CTRL_SS_DIS] && sample_tick && !half_q &&
       state != ST_OFF) |=> $stable(applied[1]);
  endproperty
  a_slow: assert property (p_slow) else $error("slow step moved on odd sample");

  property p_reached;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_RUN && status[0]) |->
        (applied[0] == (vol_l[VOL_MUTE_BIT] ? MUTE_STEP : {1'b0, vol_l[6:0]}));
  endproperty
  a_reached: assert property (p_reached) else $error("reached flag early");

  property p_immediate;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl[CTRL_SS_DIS] && state != ST_OFF) |=> applied[0] == $past(target[0]);
  endproperty
  a_immediate: assert property (p_immediate) else $error("gain not immediate");

  property p_fx_muted;
    @(posedge aclk) disable iff (!aresetn)
      ($changed(fx_active) && $past(state) == ST_FX_MUTE) |->
        ($past(applied[0]) == MUTE_STEP && $past(applied[1]) == MUTE_STEP);
  endproperty
  a_fx_muted: assert property (p_fx_muted) else $error("effects changed unmuted");

  property p_powerup;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_OFF && ctrl[CTRL_DAC_PWR]) |=> applied[0] == MUTE_STEP;
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up not muted");

  property p_powerdown;
    @(posedge aclk) disable iff (!aresetn)
      $rose(pd_done) |-> ($past(all_muted) && state == ST_OFF);
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("flag before mute");

  property p_rate;
    @(posedge aclk) disable iff (!aresetn)
      mod_tick |=> dac_valid ##1 !dac_valid [*8];
  endproperty
  a_rate: assert property (p_rate) else $error("modulator rate wrong");

  property p_mute_zero;
    @(posedge aclk) disable iff (!aresetn)
      (mod_tick && applied[0] == MUTE_STEP) |=> dac_data.left == 16'h0000;
  endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("muted channel not silent");

  c_fx_cycle: cover property (@(posedge aclk) disable iff (!aresetn)
    state == ST_FX_MUTE ##[1:1000] state == ST_RUN);
  c_powerdown: cover property (@(posedge aclk) disable iff (!aresetn) $rose(pd_done));
  c_reached: cover property (@(posedge aclk) disable iff (!aresetn)
    state == ST_RUN && $rose(vol_reached) && applied[0] != MUTE_STEP);
endmodule

// File: core/dvs_pkg.sv
package dvs_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int REFERENCE_SAMPLE_RATE_HZ = 48_000;
  localparam int OSR_BASE = 128;
  localparam int MOD_TICK_CYCLES = CLK_HZ / (OSR_BASE * REFERENCE_SAMPLE_RATE_HZ);
  localparam int GROUP_DELAY = 21;
  localparam int NUM_INPUTS = 6;
  localparam logic [7:0] MUTE_STEP = 8'h80;
  localparam logic [3:0] IN_MUTE_LEVEL = 4'h8;
  // Register indexes; byte address is four times the index.
  localparam logic [6:0] IDX_CTRL = 7'h00;
  localparam logic [6:0] IDX_VOL_L = 7'h01;
  localparam logic [6:0] IDX_VOL_R = 7'h02;
  localparam logic [6:0] IDX_MASTER = 7'h03;
  localparam logic [6:0] IDX_RATE = 7'h04;
  localparam logic [6:0] IDX_STATUS = 7'h05;
  localparam logic [6:0] IDX_IN_LEVEL = 7'h06;
  localparam logic [6:0] IDX_IN_ROUTE = 7'h07;
  localparam logic [6:0] IDX_PGA_SS = 7'h08;
  localparam logic [6:0] IDX_DRANGE = 7'h6D;
  // Control, volume and range register fields.
  localparam int CTRL_DAC_PWR = 0;
  localparam int CTRL_ANA_L_PWR = 1;
  localparam int CTRL_ANA_R_PWR = 2;
  localparam int CTRL_SS_DIS = 3;
  localparam int CTRL_SS_SLOW = 4;
  localparam int CTRL_DEEMPH = 5;
  localparam int CTRL_EFFECTS = 6;
  localparam int CTRL_CM_LSB = 8;
  localparam int VOL_MUTE_BIT = 7;
  localparam int DRANGE_LSB = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] VOL_RESET = 32'h0000_0000;
  localparam logic [31:0] RATE_RESET = 32'h0000_0001;
  localparam logic [31:0] DRANGE_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } dvs_sample_type;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RUN = 3'b001,
    ST_FX_MUTE = 3'b010,
    ST_PD_MUTE = 3'b011
  } dvs_state_type;
endpackage

// File: testbench/dvs_src.sv
`timescale 1ns/1ps
module dvs_src
  import dvs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_ready,
  output logic in_valid,
  output dvs_sample_type in_sample
);
  // ----------------------------------------
  // Sample source
  // ----------------------------------------
  // A ramp keeps both channels moving so a stuck data path shows.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_valid <= 1'b0;
      in_sample <= '0;
    end else begin
      in_valid <= 1'b1;
      if (in_ready) begin
        in_sample.left <= in_sample.left + 16'h0101;
        in_sample.right <= in_sample.right - 16'h0101;
      end
    end
  end
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb
  import dvs_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, in_valid, in_ready, dac_valid;
  logic dac_power, ana_l_power, ana_r_power, fx_active, deemph_active;
  logic [1:0] bresp, rresp, cm_select, bias_current, rr;
  logic [31:0] rdata, st;
  logic [4*NUM_INPUTS-1:0] input_level;
  logic [2*NUM_INPUTS-1:0] input_route;
  dvs_sample_type in_sample, dac_data;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int t0;
  // ----------------------------------------
  // Clock, timeout and instances
  // ----------------------------------------
  // The clock never stops, so power-down stepping can always finish.
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end
  dvs_src SRC (.aclk(aclk), .aresetn(aresetn), .in_ready(in_ready), .in_valid(in_valid),
    .in_sample(in_sample));
  dvs_dac_volume DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .in_sample(in_sample), .in_valid(in_valid), .in_ready(in_ready), .dac_data(dac_data),
    .dac_valid(dac_valid), .dac_power(dac_power), .ana_l_power(ana_l_power),
    .ana_r_power(ana_r_power), .fx_active(fx_active), .deemph_active(deemph_active),
    .cm_select(cm_select), .bias_current(bias_current), .input_level(input_level),
    .input_route(input_route));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Ready lines are sampled at the edge before that edge's updates land.
  task automatic wr(input logic [6:0] idx, input logic [31:0] d, input logic [1:0] er);
    awaddr <= 32'(idx) << 2;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("write response", {29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
  endtask
  task automatic rd(input logic [6:0] idx, output logic [31:0] d, output logic [1:0] r);
    araddr <= 32'(idx) << 2;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk);
      while (in_ready !== 1'b1) @(posedge aclk);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(IDX_CTRL, st, rr);
    chk("ctrl reset", st, CTRL_RESET);
    rd(IDX_RATE, st, rr);
    chk("rate reset", st, RATE_RESET);
    rd(IDX_STATUS, st, rr);
    chk("status reset", st, 32'h0080_8003);
    rd(IDX_DRANGE, st, rr);
    chk("bias reset", {st[31:2], bias_current}, DRANGE_RESET);
    rd(7'h7F, st, rr);
    chk("unmapped read", {st[29:0], rr}, {30'h0, RESP_SLVERR});
    wr(7'h7F, 32'h1, RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_rate();
    wr(IDX_RATE, 32'h2, RESP_OKAY);
    ticks(1);
    t0 = cyc;
    ticks(1);
    chk("sample spacing", 32'(cyc - t0), 32'(OSR_BASE * MOD_TICK_CYCLES * 2));
    wr(IDX_RATE, 32'h1, RESP_OKAY);
    while (dac_valid !== 1'b1) @(posedge aclk);
    t0 = cyc;
    @(posedge aclk);
    while (dac_valid !== 1'b1) @(posedge aclk);
    chk("modulator spacing", 32'(cyc - t0), 32'(MOD_TICK_CYCLES));
    $display("test rate done");
  endtask
  task automatic t_up();
    wr(IDX_MASTER, 32'h7E, RESP_OKAY);
    wr(IDX_VOL_R, 32'h7F, RESP_OKAY);
    rd(IDX_VOL_L, st, rr);
    chk("master to left", st, 32'h7E);
    ticks(1);
    wr(IDX_CTRL, 32'h3, RESP_OKAY);
    rd(IDX_STATUS, st, rr);
    chk("power-up state", {8'h00, st[23:8], 4'h0, st[3:0]}, 32'h0080_8004);
    chk("power pins", {29'h0, dac_power, ana_l_power, ana_r_power}, 32'h6);
    ticks(1);
    rd(IDX_STATUS, st, rr);
    chk("first step", {8'h00, st[23:8], 7'h0, st[0]}, 32'h007F_7F00);
    ticks(1);
    rd(IDX_STATUS, st, rr);
    chk("second step", {8'h00, st[23:8], 7'h0, st[0]}, 32'h007F_7E01);
    $display("test power-up done");
  endtask
  task automatic t_slow();
    wr(IDX_CTRL, 32'h13, RESP_OKAY);
    wr(IDX_VOL_L, 32'h7C, RESP_OKAY);
    ticks(2);
    rd(IDX_STATUS, st, rr);
    chk("slow after two", 32'(st[15:8]), 32'h7D);
    ticks(2);
    rd(IDX_STATUS, st, rr);
    chk("slow after four", 32'(st[15:8]), 32'h7C);
    $display("test slow done");
  endtask
  task automatic t_nostep();
    ticks(1);
    wr(IDX_CTRL, 32'h0B, RESP_OKAY);
    wr(IDX_VOL_L, 32'hFC, RESP_OKAY);
    rd(IDX_STATUS, st, rr);
    chk("instant mute", 32'(st[15:8]), 32'h80);
    wr(IDX_VOL_L, 32'h7C, RESP_OKAY);
    rd(IDX_STATUS, st, rr);
    chk("instant unmute", 32'(st[15:8]), 32'h7C);
    $display("test no-step done");
  endtask
  task automatic t_fx();
    ticks(1);
    wr(IDX_CTRL, 32'h63, RESP_OKAY);
    rd(IDX_STATUS, st, rr);
    chk("fx mute phase", {27'h0, st[4:2], fx_active, deemph_active}, 32'h08);
    ticks(10);
    rd(IDX_STATUS, st, rr);
    chk("fx resumed", {21'h0, st[15:8], st[4:2]}, {21'h0, 8'h7C, 3'b101});
    chk("fx outputs", {30'h0, fx_active, deemph_active}, 32'h3);
    $display("test effects done");
  endtask
  task automatic t_pd();
    ticks(1);
    wr(IDX_CTRL, 32'h60, RESP_OKAY);
    rd(IDX_STATUS, st, rr);
    chk("pd stepping", 32'(st[3:1]), 32'h6);
    ticks(6);
    rd(IDX_STATUS, st, rr);
    chk("pd done", {21'h0, st[15:8], st[3:1]}, {21'h0, 8'h80, 3'b001});
    chk("pd pins", {30'h0, dac_power, ana_l_power}, 32'h0);
    while (dac_valid !== 1'b1) @(posedge aclk);
    chk("pd silent", dac_data, 32'h0);
    $display("test power-down done");
  endtask
  task automatic t_misc();
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CTRL, 32'h60 | (i << CTRL_CM_LSB), RESP_OKAY);
      chk("common mode", 32'(cm_select), i);
    end
    wr(IDX_DRANGE, 32'hC0, RESP_OKAY);
    wr(IDX_PGA_SS, 32'h1, RESP_OKAY);
    wr(IDX_IN_LEVEL, 32'h3F, RESP_OKAY);
    wr(IDX_IN_ROUTE, 32'h2105, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("bias", 32'(bias_current), 32'h3);
    chk("input level", 32'(input_level[7:0]), 32'h38);
    chk("input route", 32'(input_route), {20'h0, 6'h21, 6'h05});
    wr(IDX_PGA_SS, 32'h0, RESP_OKAY);
    ticks(1);
    wr(IDX_IN_LEVEL, 32'h0, RESP_OKAY);
    ticks(1);
    @(posedge aclk);
    chk("input level step", 32'(input_level[7:0]), 32'h27);
    $display("test misc done");
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_rate();
    t_up();
    t_slow();
    t_nostep();
    t_fx();
    t_pd();
    t_misc();
    end_sim();
  end
endmodule
